// *** hdl/icc_input_capture.v ***
// Input capture channel with control register, capture buffer and interrupt
// ----------------------------------------
// ----------------------------------------
//
// Strobed register access and the address map were decided locally.
`include "icc_defines.vh"

module icc_input_capture #(
  parameter DEPTH = 4,
  parameter AW = 2,
  parameter TW = 16
) (
  input wire clk_sys,
  input wire rst_n,
  input wire [3:0] addr,
  input wire [15:0] wdata,
  input wire wr_en,
  input wire rd_en,
  output reg [15:0] rdata,
  input wire cap_in,
  input wire cpu_idle,
  input wire cpu_sleep,
  input wire timer_two_clock,
  input wire timer_three_clock,
  input wire timer_four_clock,
  input wire timer_five_clock,
  input wire timer_extra_clock,
  output reg irq
);

  // ----------------------------------------
  // Reset and input synchronisers
  // ----------------------------------------
  reg [1:0] rst_sync_r;
  wire rst_ok_n = rst_sync_r[1];
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end

  // Pin and timer clocks are sampled as levels; the first stage feeds only the second
  wire [5:0] raw_in = {timer_extra_clock, timer_five_clock, timer_four_clock,
                       timer_three_clock, timer_two_clock, cap_in};
  wire [5:0] sync2_w;
  wire [5:0] sync3_w;
  genvar g;

  generate
    for (g = 0; g < 6; g = g + 1) begin : g_sync
      reg s1_r;
      reg s2_r;
      reg s3_r;

      always @(posedge clk_sys or negedge rst_ok_n) begin
        if (!rst_ok_n) begin
          s1_r <= 1'b0;
          s2_r <= 1'b0;
          s3_r <= 1'b0;
        end else begin
          s1_r <= raw_in[g];
          s2_r <= s1_r;
          s3_r <= s2_r;
        end
      end

      assign sync2_w[g] = s2_r;
      assign sync3_w[g] = s3_r;
    end
  endgenerate

  // Third stage only holds the previous level for edge detection
  wire [5:0] rise_w = sync2_w & ~sync3_w;
  wire pin_rise = rise_w[0];
  wire pin_fall = ~sync2_w[0] & sync3_w[0];

  // ----------------------------------------
  // Control register
  // ----------------------------------------
  reg [15:0] ctrl_r;
  wire [2:0] mode = ctrl_r[`ICC_MODE_HI:`ICC_MODE_LO];
  wire [2:0] tsel = ctrl_r[`ICC_TSEL_HI:`ICC_TSEL_LO];
  wire [1:0] cpi = ctrl_r[`ICC_CPI_HI:`ICC_CPI_LO];
  wire sidl = ctrl_r[`ICC_SIDL_BIT];
  reg [2:0] stat_r;
  reg [2:0] mask_r;
  reg ovf_r;
  wire wr_ctrl = wr_en && (addr == `ICC_ADDR_CTRL);
  wire wr_stat = wr_en && (addr == `ICC_ADDR_STAT);
  wire wr_mask = wr_en && (addr == `ICC_ADDR_MASK);
  wire rd_data = rd_en && (addr == `ICC_ADDR_DATA);

  always @(posedge clk_sys or negedge rst_ok_n) begin
    if (!rst_ok_n) begin
      ctrl_r <= `ICC_CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl_r <= wdata & `ICC_CTRL_WMASK;
    end
  end

  // Mask bits line up with the status bits
  always @(posedge clk_sys or negedge rst_ok_n) begin
    if (!rst_ok_n) begin
      mask_r <= 3'h0;
    end else if (wr_mask) begin
      mask_r <= wdata[2:0];
    end
  end

  // ----------------------------------------
  // Time base
  // ----------------------------------------
  // Selected timer clock advances the time base on each synchronised rising edge; the peripheral clock selection advances it every cycle
  function tb_tick;
    input [2:0] sel;
    input [5:0] rises;
    begin
      case (sel)
        `ICC_TB_PERIPH: tb_tick = 1'b1;
        `ICC_TB_EXTRA: tb_tick = rises[5];
        `ICC_TB_T5: tb_tick = rises[4];
        `ICC_TB_T4: tb_tick = rises[3];
        `ICC_TB_T2: tb_tick = rises[1];
        `ICC_TB_T3: tb_tick = rises[2];
        default: tb_tick = 1'b0;
      endcase
    end
  endfunction

  // Halted in sleep, or in idle with stop-in-idle set; counting and capture both freeze
  wire halted = cpu_sleep || (cpu_idle && sidl);

  // Only the five capture modes run the timer, buffer and counters
  function is_cap_mode;
    input [2:0] m;
    begin
      case (m)
        `ICC_MODE_OFF: is_cap_mode = 1'b0;
        `ICC_MODE_UNUSED: is_cap_mode = 1'b0;
        `ICC_MODE_WAKE: is_cap_mode = 1'b0;
        default: is_cap_mode = 1'b1;
      endcase
    end
  endfunction

  wire cap_modes = is_cap_mode(mode);
  wire active = cap_modes && !halted;
  reg [TW-1:0] timer_r;
  always @(posedge clk_sys or negedge rst_ok_n) begin
    if (!rst_ok_n) begin
      timer_r <= {TW{1'b0}};
    end else if (!cap_modes) begin
      timer_r <= {TW{1'b0}};
    end else if (active && tb_tick(tsel, rise_w)) begin
      timer_r <= timer_r + 1'b1;
    end
  end

  // ----------------------------------------
  // Edge selection and prescaler
  // ----------------------------------------
  reg [3:0] pre_r;
  reg edge_hit;
  always @* begin
    case (mode)
      `ICC_MODE_EVERY: edge_hit = pin_rise | pin_fall;
      `ICC_MODE_RISE: edge_hit = pin_rise;
      `ICC_MODE_FALL: edge_hit = pin_fall;
      `ICC_MODE_PS4: edge_hit = pin_rise && (pre_r[1:0] == 2'h3);
      `ICC_MODE_PS16: edge_hit = pin_rise && (pre_r == 4'hf);
      default: edge_hit = 1'b0;
    endcase
  end
  wire capture = active && edge_hit;

  always @(posedge clk_sys or negedge rst_ok_n) begin
    if (!rst_ok_n) begin
      pre_r <= 4'h0;
    end else if (!cap_modes || wr_ctrl) begin
      // Changing the mode restarts the prescale count
      pre_r <= 4'h0;
    end else if (active && pin_rise) begin
      pre_r <= pre_r + 4'h1;
    end
  end

  // ----------------------------------------
  // Capture buffer
  // ----------------------------------------
  // Count is one bit wider than the pointers so full and empty differ
  localparam [AW:0] FULL_C = DEPTH[AW:0];
  localparam [AW:0] ONE_C = {{AW{1'b0}}, 1'b1};

  reg [TW-1:0] buf_r [0:DEPTH-1];
  reg [AW-1:0] wp_r;
  reg [AW-1:0] rp_r;
  reg [AW:0] cnt_r;
  wire full = (cnt_r == FULL_C);
  wire empty = (cnt_r == {(AW+1){1'b0}});
  wire push = capture && !full;
  wire pop = rd_data && !empty;
  integer i;

  // Storage is not flushed with the pointers; a stale word is never readable
  always @(posedge clk_sys or negedge rst_ok_n) begin
    if (!rst_ok_n) begin
      for (i = 0; i < DEPTH; i = i + 1) begin
        buf_r[i] <= {TW{1'b0}};
      end
    end else if (push) begin
      buf_r[wp_r] <= timer_r;
    end
  end

  always @(posedge clk_sys or negedge rst_ok_n) begin
    if (!rst_ok_n) begin
      wp_r <= {AW{1'b0}};
      rp_r <= {AW{1'b0}};
    end else if (!cap_modes) begin
      // Turning the channel off discards held captures
      wp_r <= {AW{1'b0}};
      rp_r <= {AW{1'b0}};
    end else begin
      if (push) begin
        wp_r <= wp_r + 1'b1;
      end
      if (pop) begin
        rp_r <= rp_r + 1'b1;
      end
    end
  end

  always @(posedge clk_sys or negedge rst_ok_n) begin
    if (!rst_ok_n) begin
      cnt_r <= {(AW+1){1'b0}};
    end else if (!cap_modes) begin
      cnt_r <= {(AW+1){1'b0}};
    end else if (push && !pop) begin
      cnt_r <= cnt_r + 1'b1;
    end else if (pop && !push) begin
      cnt_r <= cnt_r - 1'b1;
    end
  end

  // Overflow stays until the read that takes the last held word, even if a capture lands in that cycle, or the channel is off
  always @(posedge clk_sys or negedge rst_ok_n) begin
    if (!rst_ok_n) begin
      ovf_r <= 1'b0;
    end else if (capture && full) begin
      ovf_r <= 1'b1;
    end else if (!cap_modes || (pop && cnt_r == ONE_C)) begin
      ovf_r <= 1'b0;
    end
  end

  // ----------------------------------------
  // Captures per interrupt
  // ----------------------------------------
  // Counts captures since the last capture interrupt; a control write restarts it
  reg [1:0] ev_cnt_r;
  wire cpi_bypass = (mode == `ICC_MODE_EVERY);
  wire cap_irq = capture && (cpi_bypass || (ev_cnt_r == cpi));
  always @(posedge clk_sys or negedge rst_ok_n) begin
    if (!rst_ok_n) begin
      ev_cnt_r <= 2'h0;
    end else if (!cap_modes || wr_ctrl || cap_irq) begin
      ev_cnt_r <= 2'h0;
    end else if (capture) begin
      ev_cnt_r <= ev_cnt_r + 2'h1;
    end
  end

  // Wake mode ignores every other field and only flags pin rises in low power
  // It needs no time base, so it still works while the capture path is halted
  wire wake_ev = (mode == `ICC_MODE_WAKE) && pin_rise && (cpu_sleep || cpu_idle);

  // ----------------------------------------
  // Status, mask and interrupt
  // ----------------------------------------
  wire [2:0] ev_w;
  assign ev_w[`ICC_EV_CAPT] = cap_irq;
  assign ev_w[`ICC_EV_OVF] = capture && full;
  assign ev_w[`ICC_EV_WAKE] = wake_ev;
  // Set beats clear so an event in the clearing cycle survives
  wire [2:0] stat_nxt;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_stat
      assign stat_nxt[g] = ev_w[g] | (stat_r[g] & ~(wr_stat & wdata[g]));
    end
  endgenerate

  always @(posedge clk_sys or negedge rst_ok_n) begin
    if (!rst_ok_n) begin
      stat_r <= 3'h0;
    end else begin
      stat_r <= stat_nxt;
    end
  end

  // Interrupt follows the next status value so it rises with the status bit
  always @(posedge clk_sys or negedge rst_ok_n) begin
    if (!rst_ok_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(stat_nxt & mask_r);
    end
  end

  // ----------------------------------------
  // Read port
  // ----------------------------------------
  // A data read pops; reading an empty buffer returns zero and pops nothing
  reg [15:0] rd_nxt;

  always @* begin
    rd_nxt = 16'h0000;
    case (addr)
      `ICC_ADDR_CTRL: begin
        rd_nxt = ctrl_r & `ICC_CTRL_WMASK;
        // The flush lags a mode write by one cycle, so the flags are gated here
        rd_nxt[`ICC_OV_BIT] = ovf_r && cap_modes;
        rd_nxt[`ICC_BNE_BIT] = !empty && cap_modes;
      end
      `ICC_ADDR_STAT: rd_nxt = {13'h0000, stat_r};
      `ICC_ADDR_MASK: rd_nxt = {13'h0000, mask_r};
      `ICC_ADDR_DATA: rd_nxt = empty ? 16'h0000 : buf_r[rp_r];
      `ICC_ADDR_TIMER: rd_nxt = timer_r;
      default: rd_nxt = 16'h0000;
    endcase
  end
  always @(posedge clk_sys or negedge rst_ok_n) begin
    if (!rst_ok_n) begin
      rdata <= 16'h0000;
    end else if (rd_en) begin
      rdata <= rd_nxt;
    end else begin
      rdata <= 16'h0000;
    end
  end

endmodule // icc_input_capture

// *** hdl/icc_defines.vh ***
// Constants for the input capture control block
`ifndef ICC_DEFINES_VH
`define ICC_DEFINES_VH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define ICC_ADDR_CTRL 4'h0
`define ICC_ADDR_STAT 4'h1
`define ICC_ADDR_MASK 4'h2
`define ICC_ADDR_DATA 4'h3
`define ICC_ADDR_TIMER 4'h4
// ----------------------------------------
// Control register fields
// ----------------------------------------
`define ICC_SIDL_BIT 13
`define ICC_TSEL_HI 12
`define ICC_TSEL_LO 10
`define ICC_CPI_HI 6
`define ICC_CPI_LO 5
`define ICC_OV_BIT 4
`define ICC_BNE_BIT 3
`define ICC_MODE_HI 2
`define ICC_MODE_LO 0
`define ICC_CTRL_WMASK 16'h3c67
`define ICC_CTRL_RESET 16'h0000
// ----------------------------------------
// Modes and time base codes
// ----------------------------------------
`define ICC_MODE_OFF 3'h0
`define ICC_MODE_EVERY 3'h1
`define ICC_MODE_RISE 3'h2
`define ICC_MODE_FALL 3'h3
`define ICC_MODE_PS4 3'h4
`define ICC_MODE_PS16 3'h5
`define ICC_MODE_UNUSED 3'h6
`define ICC_MODE_WAKE 3'h7
`define ICC_TB_T3 3'h0
`define ICC_TB_T2 3'h1
`define ICC_TB_T4 3'h2
`define ICC_TB_T5 3'h3
`define ICC_TB_EXTRA 3'h4
`define ICC_TB_PERIPH 3'h7
// ----------------------------------------
// Status and interrupt bits
// ----------------------------------------
`define ICC_EV_CAPT 0
`define ICC_EV_OVF 1
`define ICC_EV_WAKE 2
`endif

// *** testbench/icc_input_capture_checker.sv ***
// Assertion checker for the input capture control block
module icc_input_capture_checker #(
  parameter DEPTH = 4,
  parameter AW = 2,
  parameter TW = 16
) (
  input wire clk_sys,
  input wire rst_n,
  input wire [3:0] addr,
  input wire [15:0] wdata,
  input wire wr_en,
  input wire rd_en,
  input wire [15:0] rdata,
  input wire irq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] ctl_r;
  logic [2:0] msk_r;
  // Shadow of the writable fields, rebuilt from bus writes only
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctl_r <= 16'h0000;
      msk_r <= 3'h0;
    end else if (wr_en && addr == 4'h0) begin
      ctl_r <= wdata & 16'h3c67;
    end else if (wr_en && addr == 4'h2) begin
      msk_r <= wdata[2:0];
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  ctrl_unused_a: assert property (rd_en && addr == 4'h0 |=> (rdata & 16'hc380) == 16'h0)
    else $error("control unused bits not zero");
  ctrl_rdback_a: assert property (rd_en && addr == 4'h0 |=> (rdata & 16'h3c67) == ctl_r)
    else $error("control fields differ from last write");
  wr_rd_a: assert property (wr_en && addr == 4'h0 ##1 rd_en && addr == 4'h0 |=>
    (rdata & 16'h3c67) == ($past(wdata, 2) & 16'h3c67)) else $error("control readback wrong");
  read_idle_a: assert property (!rd_en |=> rdata == 16'h0000)
    else $error("read data outside read slot");
  unmapped_a: assert property (rd_en && addr > 4'h4 |=> rdata == 16'h0000)
    else $error("unmapped read not zero");
  mode_off_a: assert property (rd_en && addr == 4'h0 &&
    (ctl_r[2:0] == 3'h0 || ctl_r[2:1] == 2'b11) |=> rdata[4:3] == 2'b00)
    else $error("buffer flags set while channel off");
  ov_bne_a: assert property (rdata[4] && $past(rd_en && addr == 4'h0) |-> rdata[3])
    else $error("overflow without buffered data");
  irq_mask_a: assert property (msk_r == 3'h0 && $past(msk_r) == 3'h0 |-> !irq)
    else $error("interrupt while fully masked");
  cover property (rd_en && addr == 4'h0 ##1 rdata[4]);
  cover property ($rose(irq));
  cover property (rd_en && addr == 4'h3);
endmodule // icc_input_capture_checker

bind icc_input_capture icc_input_capture_checker #(.DEPTH(DEPTH), .AW(AW), .TW(TW)) u_chk (
  .clk_sys(clk_sys), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr_en(wr_en),
  .rd_en(rd_en), .rdata(rdata), .irq(irq));

// *** testbench/icc_pin_model.sv ***
// Model of the capture pin source and the on-chip timer clocks
module icc_pin_model (
  input wire clk_sys,
  input wire rst_n,
  input wire pin_req,
  output logic cap_in,
  output logic [4:0] tclk
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] cnt_r;
  // Ticks come from the system clock, so every source is synchronous
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 5'h00;
      cap_in <= 1'b0;
    end else begin
      cnt_r <= cnt_r + 5'h01;
      cap_in <= pin_req;
    end
  end
  assign tclk = {cnt_r[1], cnt_r[2], cnt_r[3], cnt_r[4], cnt_r[1]};
endmodule // icc_pin_model

// *** testbench/tb_input_capture_control.sv ***
// Self-checking testbench for the input capture control block
module tb_input_capture_control;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0000;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic cpu_idle = 1'b0;
  logic cpu_sleep = 1'b0;
  logic pin_req = 1'b0;
  logic rd_d = 1'b0;
  logic cap_in, irq;
  logic [15:0] rdata;
  logic [4:0] tclk;
  logic [2:0] tb;
  logic [31:0] exp_q[$];
  int caps;
  int cap_tab[8] = '{0, 32, 16, 16, 4, 1, 0, 0};
  logic [2:0] tsel_tab[6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h7};
  int miscompares = 0;
  int samples_checked = 0;
  icc_pin_model u_pin (.clk_sys(clk_sys), .rst_n(rst_n), .pin_req(pin_req),
    .cap_in(cap_in), .tclk(tclk));
  icc_input_capture dut (.clk_sys(clk_sys), .rst_n(rst_n), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .cap_in(cap_in), .cpu_idle(cpu_idle),
    .cpu_sleep(cpu_sleep), .timer_two_clock(tclk[0]), .timer_three_clock(tclk[1]),
    .timer_four_clock(tclk[2]), .timer_five_clock(tclk[3]), .timer_extra_clock(tclk[4]),
    .irq(irq));
  initial forever #10 clk_sys = ~clk_sys;
  // ----
  // Bus tasks and the read-data watcher
  // ----
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
    samples_checked++;
    if (s !== e) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    wr_en <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk_sys);
    wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] m, input logic [15:0] e);
    @(posedge clk_sys);
    rd_en <= 1'b1;
    addr <= a;
    exp_q.push_back({m, e & m});
    @(posedge clk_sys);
    rd_en <= 1'b0;
  endtask
  task automatic pulse(input int n);
    repeat (n) begin
      @(posedge clk_sys);
      pin_req <= 1'b1;
      repeat (3) @(posedge clk_sys);
      pin_req <= 1'b0;
      repeat (3) @(posedge clk_sys);
    end
    repeat (6) @(posedge clk_sys);
  endtask
  task automatic irq_is(input logic e);
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
    chk("irq", {15'h0, e}, {15'h0, irq});
  endtask
  // Read data stand only in the cycle after the strobe
  always @(posedge clk_sys) begin
    if (rd_d) begin
      chk("rdata", exp_q[0][15:0], rdata & exp_q[0][31:16]);
      void'(exp_q.pop_front());
    end
    rd_d <= rd_en;
  end
  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    #400000;
    miscompares++;
    final_report();
  end
  // ----
  // Scenarios
  // ----
  initial begin
    void'($urandom(32'h9dfe11eb));
    repeat (8) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    rd(4'h0, 16'hffff, 16'h0000);
    rd(4'h9, 16'hffff, 16'h0000);
    wr(4'h0, 16'hffff);
    rd(4'h0, 16'hffff, 16'h3c67);
    wr(4'h2, 16'h0007);
    // Sixteen pulses per mode; more captures than the buffer of four must overflow
    for (int m = 0; m < 8; m++) begin
      tb = tsel_tab[$urandom_range(5, 0)];
      caps = cap_tab[m];
      wr(4'h0, 16'h0000);
      wr(4'h1, 16'h0007);
      wr(4'h0, {3'h0, tb, 3'h0, 2'b11, 2'b00, m[2:0]});
      pulse(16);
      rd(4'h0, 16'h0018, {11'h0, caps > 4, caps > 0, 3'h0});
      rd(4'h1, 16'h0001, {15'h0, m == 1 ? caps > 0 : caps >= 4});
      irq_is(caps >= 4);
      repeat ((caps > 4) ? 4 : caps) rd(4'h3, 16'h0000, 16'h0000);
      rd(4'h0, 16'h0018, 16'h0000);
    end
    for (int c = 0; c < 4; c++) begin
      wr(4'h0, 16'h0000);
      wr(4'h1, 16'h0007);
      wr(4'h0, {9'h000, c[1:0], 5'h02});
      pulse(c);
      rd(4'h1, 16'h0001, 16'h0000);
      pulse(1);
      rd(4'h1, 16'h0001, 16'h0001);
    end
    cpu_idle <= 1'b1;
    wr(4'h0, 16'h0000);
    wr(4'h0, 16'h2002);
    pulse(2);
    rd(4'h0, 16'h0008, 16'h0000);
    wr(4'h0, 16'h0002);
    pulse(2);
    rd(4'h0, 16'h0008, 16'h0008);
    cpu_sleep <= 1'b1;
    wr(4'h0, 16'h0000);
    wr(4'h1, 16'h0007);
    wr(4'h0, 16'h0007);
    pulse(1);
    rd(4'h1, 16'h0004, 16'h0004);
    rd(4'h0, 16'h0008, 16'h0000);
    irq_is(1'b1);
    wr(4'h2, 16'h0000);
    irq_is(1'b0);
    wr(4'h2, 16'h0004);
    irq_is(1'b1);
    wr(4'h1, 16'h0004);
    irq_is(1'b0);
    repeat (4) @(posedge clk_sys);
    final_report();
  end
endmodule // tb_input_capture_control
